// ### core/pm_ctrl_cfg.svh
// Constants of the power mode and reset controller: offsets, fields,
// reset values and timing counts. Assumes a 50 MHz system clock.
`ifndef PM_CTRL_CFG_SVH
`define PM_CTRL_CFG_SVH

// Register byte offsets on the Wishbone slave
`define PMR_ADR_POWER_CONTROL_REGISTER 4'h0
`define PMR_ADR_CFG 4'h4
`define PMR_ADR_STAT 4'h8

// power_control_register fields
`define PMR_PC_IDLE 0
`define PMR_PC_DOWN 1
`define PMR_PC_SERW 2
`define PMR_PC_INT0W 3

// clock_synth_config_register fields
`define PMR_CFG_OSCPD 0
`define PMR_CFG_TICKEEP 1

// Status register fields
`define PMR_ST_STATE_LSB 0
`define PMR_ST_CAUSE_LSB 4
`define PMR_ST_DL 7

// Reset values
`define PMR_POWER_CONTROL_REGISTER_RST 2'h0
`define PMR_CFG_RST 2'h0

// Timing: clock rate, power-on hold, PLL relock wait, wake guard
`define PMR_CLK_MHZ 50
`define PMR_POR_MS 128
`define PMR_POR_CYC (`PMR_POR_MS * 1000 * `PMR_CLK_MHZ)
`define PMR_RELOCK_US 2
`define PMR_RELOCK_CYC (`PMR_RELOCK_US * `PMR_CLK_MHZ)
`define PMR_EXTERNAL_INTERRUPT_ZERO_GUARD 2'h2

`endif

// ### core/pm_ctrl_pkg.sv
// Types shared by the power mode and reset controller files.
// Assumes nothing of its surroundings.
package pm_ctrl_pkg;

  // Power state, one-hot
  typedef enum logic [3:0] {
    S_RUN = 4'b0001,
    S_IDLE = 4'b0010,
    S_DOWN = 4'b0100,
    S_RELOCK = 4'b1000
  } pm_state_t;

endpackage : pm_ctrl_pkg

// ### core/hold_timer.sv
// Cycle counter that raises done after CYCLES cycles of run.
// Assumes clear is synchronous and CYCLES fits in 23 bits.
module hold_timer #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic done_o
);

  // Last count value before done
  localparam logic [22:0] LAST = 23'(CYCLES - 1);

  logic [22:0] count_q; // Elapsed cycles

  // Count while running, stop once done
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      count_q <= 23'h0;
      done_o <= 1'b0;
    end else if (run_i && !done_o) begin
      count_q <= count_q + 23'h1;
      done_o <= (count_q == LAST);
    end
  end

endmodule : hold_timer

// ### core/strap_sampler.sv
// Boot strap pin: drives high as an output, samples at reset release.
// Assumes hold_i is the device reset, synchronous to clk_i.
module strap_sampler (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic strap_in_i,
  output logic strap_out_o,
  output logic strap_oe_o,
  output logic download_o
);

  logic held_q; // Reset seen last cycle

  // Pin is an input only while reset holds
  always_ff @(posedge clk_i) begin
    held_q <= hold_i;
    strap_out_o <= 1'b1;
    strap_oe_o <= !hold_i;
  end

  // Low at the release edge selects download mode
  always_ff @(posedge clk_i) begin
    if (held_q && !hold_i) begin
      download_o <= !strap_in_i;
    end
  end

endmodule : strap_sampler

// ### core/power_mode_and_reset_control.sv
// Power mode and reset controller: idle, power-down, wake-up, power-on
// reset and boot strap. Assumes one 50 MHz clock, a classic Wishbone
// master, and wake and supply inputs synchronous to the clock.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`include "pm_ctrl_cfg.svh"

module power_mode_and_reset_control
  import pm_ctrl_pkg::*;
#(
  parameter int unsigned POR_CYCLES = `PMR_POR_CYC,
  parameter bit FIVE_VOLT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_reset_i,
  input wire logic supply_above_low_i,
  input wire logic supply_above_high_i,
  input wire logic supply_above_1v_i,
  input wire logic irq_enabled_i,
  input wire logic tic_irq_i,
  input wire logic serial_irq_i,
  input wire logic ext_irq0_n_i,
  input wire logic strap_in_i,
  output logic strap_out_o,
  output logic strap_oe_o,
  output logic download_mode_o,
  output logic core_reset_o,
  output logic core_clk_en_o,
  output logic periph_clk_en_o,
  output logic pll_en_o,
  output logic osc_en_o,
  output logic interval_counter_en_o,
  output logic port_hold_o,
  output logic dac_hold_o,
  output logic dac_hiz_o,
  output logic wake_irq_o
);

  // Address match, used by every register decode
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction : hit

  pm_state_t state_q; // Current power state
  pm_state_t state_d; // Next power state
  logic serial_wake_en_q; // Serial interrupt may end power-down
  logic external_interrupt_zero_wake_en_q; // Interrupt zero may end power-down
  logic osc_pd_q; // Oscillator halts in power-down
  logic tic_keep_q; // Interval counter runs in power-down unless the oscillator halts
  logic [2:0] cause_q; // Wake cause: external_interrupt_zero, serial, interval
  logic [1:0] guard_q; // Interrupt zero ignore window
  logic drop_q; // Supply fell, awaiting full discharge
  logic ack_q; // Bus acknowledge
  logic [31:0] rdat_q; // Read data

  // Power-on reset
  wire supply_ok_w = FIVE_VOLT ? supply_above_high_i : supply_above_low_i;
  wire por_run_w = supply_ok_w && !drop_q;
  wire por_done_w;
  // Low supply holds reset at once, without waiting for the timer to clear
  wire por_hold_w = !por_done_w || !supply_ok_w;
  wire dev_rst_w = rst_i || ext_reset_i || por_hold_w;

  // Bus decode
  wire req_w = wb_cyc_i && wb_stb_i;
  wire wr_w = req_w && wb_we_i && ack_q && wb_sel_i[0];
  wire wr_power_control_register_w = wr_w && hit(wb_adr_i, `PMR_ADR_POWER_CONTROL_REGISTER);
  wire wr_cfg_w = wr_w && hit(wb_adr_i, `PMR_ADR_CFG);
  wire idle_req_w = wr_power_control_register_w && wb_dat_i[`PMR_PC_IDLE];
  wire down_req_w = wr_power_control_register_w && wb_dat_i[`PMR_PC_DOWN];

  // Wake sources
  wire tic_wake_w = tic_irq_i;
  wire ser_wake_w = serial_irq_i && serial_wake_en_q;
  wire external_interrupt_zero_wake_w = !ext_irq0_n_i && external_interrupt_zero_wake_en_q && (guard_q == 2'h0);
  wire wake_any_w = tic_wake_w || ser_wake_w || external_interrupt_zero_wake_w;
  wire relock_done_w;
  wire enter_down_w = (state_d == S_DOWN) && (state_q != S_DOWN);

  // Read mux
  wire [31:0] power_control_register_rd_w = {28'h0, external_interrupt_zero_wake_en_q, serial_wake_en_q,
                           state_q == S_DOWN, state_q == S_IDLE};
  wire [31:0] cfg_rd_w = {30'h0, tic_keep_q, osc_pd_q};
  wire [31:0] stat_rd_w = {24'h0, download_mode_o, cause_q, state_q};
  wire [31:0] rd_w = hit(wb_adr_i, `PMR_ADR_POWER_CONTROL_REGISTER) ? power_control_register_rd_w :
                     hit(wb_adr_i, `PMR_ADR_CFG) ? cfg_rd_w :
                     hit(wb_adr_i, `PMR_ADR_STAT) ? stat_rd_w : 32'h0;

  // Power-on hold timer, restarted by every power cycle
  hold_timer #(
    .CYCLES(POR_CYCLES)
  ) u_por (
    .clk_i(clk_i),
    .clear_i(rst_i || !por_run_w),
    .run_i(por_run_w),
    .done_o(por_done_w)
  );

  // PLL relock wait after power-down
  hold_timer #(
    .CYCLES(`PMR_RELOCK_CYC)
  ) u_relock (
    .clk_i(clk_i),
    .clear_i(state_q != S_RELOCK),
    .run_i(1'b1),
    .done_o(relock_done_w)
  );

  // Strap pin capture at reset release
  strap_sampler u_strap (
    .clk_i(clk_i),
    .hold_i(dev_rst_w),
    .strap_in_i(strap_in_i),
    .strap_out_o(strap_out_o),
    .strap_oe_o(strap_oe_o),
    .download_o(download_mode_o)
  );

  // Falling supply keeps reset until it drops below 1 V
  always_ff @(posedge clk_i) begin
    if (rst_i || !supply_above_1v_i) begin
      drop_q <= 1'b0;
    end else if (!supply_ok_w && por_done_w) begin
      drop_q <= 1'b1;
    end
  end

  // Next power state
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (down_req_w) begin
          state_d = S_DOWN;
        end else if (idle_req_w) begin
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (irq_enabled_i) begin
          state_d = S_RUN;
        end
      end
      S_DOWN: begin
        if (wake_any_w) begin
          state_d = S_RELOCK;
        end
      end
      S_RELOCK: begin
        if (relock_done_w) begin
          state_d = S_RUN;
        end
      end
      default: begin
        state_d = S_RUN;
      end
    endcase
    if (dev_rst_w) begin
      state_d = S_RUN;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    state_q <= state_d;
  end

  // Software controls, defaults under any device reset
  always_ff @(posedge clk_i) begin
    if (dev_rst_w) begin
      {external_interrupt_zero_wake_en_q, serial_wake_en_q} <= `PMR_POWER_CONTROL_REGISTER_RST;
      {tic_keep_q, osc_pd_q} <= `PMR_CFG_RST;
    end else begin
      if (wr_power_control_register_w) begin
        serial_wake_en_q <= wb_dat_i[`PMR_PC_SERW];
        external_interrupt_zero_wake_en_q <= wb_dat_i[`PMR_PC_INT0W];
      end
      if (wr_cfg_w) begin
        osc_pd_q <= wb_dat_i[`PMR_CFG_OSCPD];
        tic_keep_q <= wb_dat_i[`PMR_CFG_TICKEEP];
      end
    end
  end

  // Wake cause, cleared on each entry into power-down
  always_ff @(posedge clk_i) begin
    if (dev_rst_w || enter_down_w) begin
      cause_q <= 3'h0;
    end else if (state_q == S_DOWN) begin
      cause_q <= cause_q | {external_interrupt_zero_wake_w, ser_wake_w, tic_wake_w};
    end
  end

  // Interrupt zero ignored just after entry
  always_ff @(posedge clk_i) begin
    if (dev_rst_w) begin
      guard_q <= 2'h0;
    end else if (enter_down_w) begin
      guard_q <= `PMR_EXTERNAL_INTERRUPT_ZERO_GUARD;
    end else if (guard_q != 2'h0) begin
      guard_q <= guard_q - 2'h1;
    end
  end

  // Clock and pin controls follow the next state; reset follows the device reset
  always_ff @(posedge clk_i) begin
    core_reset_o <= dev_rst_w;
    core_clk_en_o <= (state_d == S_RUN);
    periph_clk_en_o <= (state_d != S_DOWN);
    pll_en_o <= (state_d != S_DOWN);
    osc_en_o <= !((state_d == S_DOWN) && osc_pd_q);
    interval_counter_en_o <= (state_d != S_DOWN) || (tic_keep_q && !osc_pd_q);
    port_hold_o <= (state_d != S_RUN);
    dac_hold_o <= (state_d == S_IDLE);
    dac_hiz_o <= (state_d == S_DOWN) || (state_d == S_RELOCK);
    wake_irq_o <= (state_q == S_RELOCK) && (state_d == S_RUN);
  end

  // Wishbone slave: ack one cycle after the request, for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req_w && !ack_q;
      rdat_q <= rd_w;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_IDLE_CLOCKS: assert property (
    state_q == S_IDLE |-> !core_clk_en_o && periph_clk_en_o && osc_en_o)
    else $error("idle clock gating wrong");

  AST_IDLE_HOLD: assert property (
    state_q == S_IDLE |-> port_hold_o && dac_hold_o && !dac_hiz_o)
    else $error("idle pins not held");

  AST_IDLE_EXIT: assert property (
    state_q == S_IDLE && irq_enabled_i |=> state_q == S_RUN && core_clk_en_o)
    else $error("idle not left on interrupt");

  AST_DOWN_CLOCKS: assert property (
    state_q == S_DOWN |-> !pll_en_o && !core_clk_en_o && (osc_en_o == !osc_pd_q))
    else $error("power-down clocks wrong");

  AST_DOWN_PERIPH: assert property (
    state_q == S_DOWN |->
      !periph_clk_en_o && (interval_counter_en_o == (tic_keep_q && !osc_pd_q)))
    else $error("power-down peripherals wrong");

  AST_DOWN_PINS: assert property (
    state_q == S_DOWN |-> port_hold_o && dac_hiz_o)
    else $error("power-down pins wrong");

  AST_EXT_RESET: assert property (
    ext_reset_i |=> core_reset_o && state_q == S_RUN && !serial_wake_en_q)
    else $error("external reset not applied");

  AST_POR_HOLD: assert property (
    !supply_ok_w |=> core_reset_o)
    else $error("reset released at low supply");

  AST_SERIAL_GATE: assert property (
    state_q == S_DOWN && serial_irq_i && !serial_wake_en_q && !tic_irq_i &&
      !external_interrupt_zero_wake_w && !dev_rst_w |=> state_q == S_DOWN)
    else $error("serial wake not gated");

  AST_WAKE_ORDER: assert property (
    state_q == S_DOWN && wake_any_w && !dev_rst_w |=>
      pll_en_o && !core_clk_en_o ##1 !core_clk_en_o)
    else $error("core clock before relock");

  AST_STRAP_LATCH: assert property (
    dev_rst_w ##1 !dev_rst_w |=> download_mode_o == !$past(strap_in_i))
    else $error("strap not latched at release");

endmodule : power_mode_and_reset_control

// ### tb/wake_source_model.sv
// Far side of the power controller: reset button, wake sources, strap.
// Assumes the bench calls its tasks right after a rising clock edge.
module wake_source_model (
  input wire logic clk_i,
  input wire logic strap_out_i,
  input wire logic strap_oe_i,
  output logic strap_pin_o,
  output logic tic_irq_o,
  output logic serial_irq_o,
  output logic ext_irq0_n_o,
  output logic ext_reset_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic jumper_q = 1'b0; // Download jumper fitted
  // Pin level: device drive, else jumper pull-down, else board pull-up
  assign strap_pin_o = strap_oe_i ? strap_out_i : !jumper_q;
  // Sources idle at time zero
  initial begin
    tic_irq_o = 1'b0;
    serial_irq_o = 1'b0;
    ext_irq0_n_o = 1'b1;
    ext_reset_o = 1'b0;
  end
  // Fit or remove the jumper
  task set_jumper(input logic j);
    jumper_q <= j;
  endtask : set_jumper
  // Four-cycle event: 0 interval, 1 serial, 2 interrupt zero, 3 reset
  task pulse(input int which);
    repeat (3) @(posedge clk_i);
    case (which)
      0: tic_irq_o <= 1'b1;
      1: serial_irq_o <= 1'b1;
      2: ext_irq0_n_o <= 1'b0;
      default: ext_reset_o <= 1'b1;
    endcase
    repeat (4) @(posedge clk_i);
    tic_irq_o <= 1'b0;
    serial_irq_o <= 1'b0;
    ext_irq0_n_o <= 1'b1;
    ext_reset_o <= 1'b0;
  endtask : pulse
endmodule : wake_source_model

// ### tb/testbench.sv
// Self-checking bench of the power mode and reset controller.
// Assumes a 50 MHz clock and a short power-on hold for simulation.
module testbench;
  import pm_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 20; // Shortened power-on hold
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic sup_lo, sup_hi, sup_1v, irq_en, interval_counter, ser, external_interrupt_zero_n, xrst, pin;
  logic strap_out_o, strap_oe_o, download_mode_o, core_reset_o, core_clk_en_o;
  logic periph_clk_en_o, pll_en_o, osc_en_o, interval_counter_en_o;
  logic port_hold_o, dac_hold_o, dac_hiz_o, wake_irq_o;
  logic [32:0] exp_q[$]; // Pending bus answers: check flag and value
  logic [32:0] e;
  int errors = 0, n_tests = 0, n, k;
  always #10 clk_i = !clk_i;
  power_mode_and_reset_control #(.POR_CYCLES(POR), .FIVE_VOLT(1'b0))
    i_power_mode_and_reset_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_i(xrst),
    .supply_above_low_i(sup_lo), .supply_above_high_i(sup_hi),
    .supply_above_1v_i(sup_1v), .irq_enabled_i(irq_en), .tic_irq_i(interval_counter),
    .serial_irq_i(ser), .ext_irq0_n_i(external_interrupt_zero_n), .strap_in_i(pin),
    .strap_out_o(strap_out_o), .strap_oe_o(strap_oe_o),
    .download_mode_o(download_mode_o), .core_reset_o(core_reset_o),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .pll_en_o(pll_en_o), .osc_en_o(osc_en_o),
    .interval_counter_en_o(interval_counter_en_o), .port_hold_o(port_hold_o),
    .dac_hold_o(dac_hold_o), .dac_hiz_o(dac_hiz_o), .wake_irq_o(wake_irq_o));
  wake_source_model i_wake_source_model (.clk_i(clk_i), .strap_out_i(strap_out_o),
    .strap_oe_i(strap_oe_o), .strap_pin_o(pin), .tic_irq_o(interval_counter),
    .serial_irq_o(ser), .ext_irq0_n_o(external_interrupt_zero_n), .ext_reset_o(xrst));
  // Verdict and end of run
  task tally_and_finish;
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Compare one flag
  task chk(input string nm, input logic ex, input logic got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk
  // Watcher: each answer takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      n_tests += e[32];
      if (e[32] && wb_dat_o !== e[31:0]) begin
        errors++;
        $display("wrong value wb_dat_o expected %h seen %h", e[31:0], wb_dat_o);
      end
    end
  end
  // One classic cycle; c set means the read answer is compared
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d,
      input logic [31:0] ex, input logic c);
    exp_q.push_back({c, ex});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wait_for(2, 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // Bounded wait: 0 core out of reset, 1 wake pulse, 2 bus answer
  task wait_for(input int sel, input int lim);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clk_i);
      n++;
      hit = sel == 0 ? core_reset_o === 1'b0 :
            sel == 1 ? wake_irq_o === 1'b1 : wb_ack_o === 1'b1;
      if (!hit && n >= lim) begin
        errors++;
        tally_and_finish;
      end
    end
  endtask : wait_for
  // Let updates land before looking at outputs
  task settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  // Main sequence
  initial begin
    seed = 32'h4c4a5f09;
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {sup_lo, sup_hi, sup_1v, irq_en} = 4'b0110;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    sup_lo <= 1'b1;
    wait_for(0, 200);
    chk("por_hold", 1'b1, n >= POR);
    settle;
    chk("download", 1'b0, download_mode_o);
    chk("strap_oe", 1'b1, strap_oe_o);
    chk("strap_out", 1'b1, strap_out_o);
    bus(0, 4'h8, 32'h0, 32'h1, 1);
    bus(1, 4'hc, $random(seed), 32'h0, 0);
    bus(0, 4'hc, 32'h0, 32'h0, 1);
    bus(0, 4'h4, 32'h0, 32'h0, 1);
    // Idle entry and exit
    bus(1, 4'h0, 32'h1, 32'h0, 0);
    settle;
    chk("core_clk", 1'b0, core_clk_en_o);
    chk("periph_clk", 1'b1, periph_clk_en_o & osc_en_o);
    chk("hold", 1'b1, port_hold_o & dac_hold_o);
    bus(0, 4'h8, 32'h0, 32'h2, 1);
    irq_en <= 1'b1;
    settle;
    chk("idle_exit", 1'b1, core_clk_en_o);
    irq_en <= 1'b0;
    // Power-down, interval counter kept, woken by it
    bus(1, 4'h4, 32'h2, 32'h0, 0);
    bus(1, 4'h0, 32'h2, 32'h0, 0);
    settle;
    chk("pll_core", 1'b0, pll_en_o | core_clk_en_o);
    chk("osc", 1'b1, osc_en_o);
    chk("periph", 1'b0, periph_clk_en_o);
    chk("ic_en", 1'b1, interval_counter_en_o);
    chk("pins", 1'b1, port_hold_o & dac_hiz_o);
    repeat ($random(seed) & 7) @(posedge clk_i);
    i_wake_source_model.pulse(0);
    wait_for(1, 300);
    chk("relock", 1'b1, pll_en_o & core_clk_en_o);
    bus(0, 4'h8, 32'h0, 32'h11, 1);
    // Serial then interrupt zero, the other source disabled
    for (k = 0; k < 2; k++) begin
      bus(1, 4'h0, k ? 32'ha : 32'h6, 32'h0, 0);
      i_wake_source_model.pulse(k ? 1 : 2);
      settle;
      chk("no_wake", 1'b0, pll_en_o);
      i_wake_source_model.pulse(k ? 2 : 1);
      wait_for(1, 300);
      bus(0, 4'h8, 32'h0, k ? 32'h41 : 32'h21, 1);
    end
    // Oscillator stopped, left by the reset pin with jumper fitted
    bus(1, 4'h4, 32'h3, 32'h0, 0);
    bus(1, 4'h0, 32'h2, 32'h0, 0);
    settle;
    chk("osc_off", 1'b0, osc_en_o | interval_counter_en_o);
    i_wake_source_model.set_jumper(1'b1);
    i_wake_source_model.pulse(3);
    wait_for(0, 50);
    settle;
    chk("download", 1'b1, download_mode_o);
    bus(0, 4'h4, 32'h0, 32'h0, 1);
    bus(0, 4'h0, 32'h0, 32'h0, 1);
    bus(0, 4'h8, 32'h0, 32'h81, 1);
    i_wake_source_model.set_jumper(1'b0);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(0, 50);
    settle;
    chk("download", 1'b0, download_mode_o);
    // Supply falls, returns, then a full power cycle
    sup_lo <= 1'b0;
    settle;
    chk("low_hold", 1'b1, core_reset_o);
    sup_lo <= 1'b1;
    repeat (POR + 10) @(posedge clk_i);
    chk("drop_hold", 1'b1, core_reset_o);
    {sup_lo, sup_1v} <= 2'b00;
    settle;
    sup_1v <= 1'b1;
    @(posedge clk_i);
    sup_lo <= 1'b1;
    wait_for(0, 200);
    chk("power_cycle", 1'b1, n >= POR);
    tally_and_finish;
  end
endmodule : testbench
